//--- feq_defines.svh
// Register offsets, field positions, reset values and widths of the equalizer and gain trim block.
`ifndef FEQ_DEFINES_SVH
`define FEQ_DEFINES_SVH

`define FEQ_ADDR_W          12
`define FEQ_DATA_W          16
`define FEQ_SMP_W           12
`define FEQ_COEF_W          12
`define FEQ_GAIN_W          5
`define FEQ_GAIN_REG_W      8
`define FEQ_CFG_REG_W       8
`define FEQ_FIFO_DEPTH      8

`define FEQ_OFS_GAIN_A0_DUAL    12'h350
`define FEQ_OFS_GAIN_A1_DUAL    12'h351
`define FEQ_OFS_GAIN_B0_DUAL    12'h352
`define FEQ_OFS_GAIN_B1_DUAL    12'h353
`define FEQ_OFS_GAIN_A0_SINGLE  12'h354
`define FEQ_OFS_GAIN_A1_SINGLE  12'h355
`define FEQ_OFS_GAIN_B0_SINGLE  12'h356
`define FEQ_OFS_GAIN_B1_SINGLE  12'h357
`define FEQ_OFS_CONFIG          12'h400
`define FEQ_OFS_COEFF_A_TAP0    12'h418
`define FEQ_OFS_COEFF_B_TAP0    12'h438
`define FEQ_OFS_CTRL            12'h200
`define FEQ_OFS_STATUS          12'h204

`define FEQ_RST_GAIN            8'h00
`define FEQ_RST_CONFIG          8'h00
`define FEQ_RST_COEFF           16'h0000
`define FEQ_RST_CTRL            2'h0

`define FEQ_CFG_MODE_LSB        0
`define FEQ_CFG_SCW_LSB         2
`define FEQ_CFG_MERGE_BIT       5
`define FEQ_CFG_SHARE_BIT       6
`define FEQ_SCW_MAX             3'h6
`define FEQ_SCW_BASE            16
`define FEQ_CTRL_LINK_BIT       0
`define FEQ_CTRL_SINGLE_BIT     1
`define FEQ_STAT_ACTIVE_BIT     4
`define FEQ_STAT_CFGHOT_BIT     5

`endif

//--- feq_pkg.sv
// Types shared by the equalizer and gain trim block.
package feq_pkg;

    typedef enum logic [1:0] {
        FEQ_MODE_BYPASS = 2'h0,
        FEQ_MODE_RSVD1  = 2'h1,
        FEQ_MODE_ENABLE = 2'h2,
        FEQ_MODE_RSVD3  = 2'h3
    } feq_mode_t;

    typedef logic signed [11:0] feq_coef_t;

endpackage

//--- feq_fifo.sv
// Parameterised sample FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module feq_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             i_clk,
    input  wire logic             i_arst_n,
    // Filling side.
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output var  logic             o_in_ready,
    // Draining side.
    output var  logic             o_out_valid,
    output var  logic [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("feq_fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             push;
    logic             pop;

    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;
    assign o_out_valid = (count_r != '0);
    assign o_out_data  = mem_r[rd_ptr_r];

    always_comb
    begin
        count_nxt = count_r;
        if (push && !pop)
        begin
            count_nxt = count_r + 1'b1;
        end
        else if (pop && !push)
        begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wr_ptr_r   <= '0;
            rd_ptr_r   <= '0;
            count_r    <= '0;
            o_in_ready <= 1'b0;
        end
        else
        begin
            wr_ptr_r   <= wr_ptr_r + AW'(push);
            rd_ptr_r   <= rd_ptr_r + AW'(pop);
            count_r    <= count_nxt;
            // Registered so the ready seen upstream never depends on the drain in the same cycle.
            o_in_ready <= (count_nxt != (AW + 1)'(DEPTH));
        end
    end

endmodule // feq_fifo

`default_nettype wire

//--- feq_equalizer.sv
// Equalizer configuration, fine gain trim registers and the first-tap sample path.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "feq_defines.svh"

// Overview of operation
// - Four dual-channel fine gain trims, five bits each, bits 7:5 reserved.
// - A second independent set of four trims applies in single-channel mode.
// - Trim defaults are loaded from fuse values after reset, not constants.
// - Share or merge bit makes channel B use channel A coefficients, else its own.
// - Merge bit treats both channels as one interleaved sample stream.
// - Side weight scales every coefficient except the center tap.
// - Side coefficient LSB weight is two to the setting minus sixteen, 0 to 6.
// - Mode 0 bypasses, mode 2 enables, modes 1 and 3 reserved.
// - Coefficients are signed twelve-bit values, bits 15:12 reserved.
// - Channel A tap zero register is first tap of A or merged filter.
module feq_equalizer #(
    parameter int FIFO_DEPTH = `FEQ_FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic                      i_clk,
    input  wire logic                      i_arst_n,
    // Register port.
    input  wire logic [`FEQ_ADDR_W-1:0]    i_addr,
    input  wire logic [`FEQ_DATA_W-1:0]    i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output var  logic [`FEQ_DATA_W-1:0]    o_rdata,
    // Fuse defaults, order a0, a1, b0, b1 from the low bits.
    input  wire logic [4*`FEQ_GAIN_W-1:0]  i_fuse_gain_dual,
    input  wire logic [4*`FEQ_GAIN_W-1:0]  i_fuse_gain_single,
    // Converter samples in.
    input  wire logic                      i_smp_valid,
    input  wire logic [`FEQ_SMP_W-1:0]     i_smp_a,
    input  wire logic [`FEQ_SMP_W-1:0]     i_smp_b,
    output var  logic                      o_smp_ready,
    // Equalized samples out.
    output var  logic                      o_eq_valid,
    output var  logic [`FEQ_SMP_W-1:0]     o_eq_a,
    output var  logic [`FEQ_SMP_W-1:0]     o_eq_b,
    input  wire logic                      i_eq_ready,
    // Active fine gain trims per bank.
    output var  logic [`FEQ_GAIN_W-1:0]    o_gain_trim_a0,
    output var  logic [`FEQ_GAIN_W-1:0]    o_gain_trim_a1,
    output var  logic [`FEQ_GAIN_W-1:0]    o_gain_trim_b0,
    output var  logic [`FEQ_GAIN_W-1:0]    o_gain_trim_b1
);

    localparam int SW = `FEQ_SMP_W;
    localparam int GW = `FEQ_GAIN_W;

    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 16)
    begin : g_bad_depth
        $error("feq_equalizer fifo depth must lie between 2 and 16");
    end

    // Side tap term scaled by 2^(min(scw,6)-16), added to the unity center tap and saturated.
    function automatic logic [SW-1:0] feq_tap(input logic [SW-1:0] center, input logic [SW-1:0] side,
                                              input logic [SW-1:0] coef, input logic [2:0] scw);
        logic signed [23:0] prod;
        logic signed [31:0] term;
        logic signed [31:0] sum;
        logic        [2:0]  eff;
        prod = $signed(side) * $signed(coef);
        eff  = (scw > `FEQ_SCW_MAX) ? `FEQ_SCW_MAX : scw;
        term = (32'(prod) <<< eff) >>> `FEQ_SCW_BASE;
        sum  = term + 32'($signed(center));
        if (sum > 32'sd2047)
        begin
            feq_tap = 12'h7FF;
        end
        else if (sum < -32'sd2048)
        begin
            feq_tap = 12'h800;
        end
        else
        begin
            feq_tap = sum[SW-1:0];
        end
    endfunction

    // Register file; reserved bits are stored for readback only.
    logic [`FEQ_GAIN_REG_W-1:0] gain_dual_r   [4];
    logic [`FEQ_GAIN_REG_W-1:0] gain_single_r [4];
    logic [`FEQ_CFG_REG_W-1:0]  cfg_r;
    logic [`FEQ_DATA_W-1:0]     coef_a_r;
    logic [`FEQ_DATA_W-1:0]     coef_b_r;
    logic [1:0]                 ctrl_r;
    logic                       cfg_hot_r;
    logic                       fuse_done_r;

    feq_pkg::feq_mode_t mode;
    logic               link_en;
    logic               single_mode;
    logic               merge;
    logic               share;
    logic [2:0]         scw;
    logic               filt_on;
    logic [SW-1:0]      coef_a;
    logic [SW-1:0]      coef_b_eff;
    logic               cfg_wr;

    assign mode        = feq_pkg::feq_mode_t'(cfg_r[`FEQ_CFG_MODE_LSB +: 2]);
    assign scw         = cfg_r[`FEQ_CFG_SCW_LSB +: 3];
    assign merge       = cfg_r[`FEQ_CFG_MERGE_BIT];
    assign share       = cfg_r[`FEQ_CFG_SHARE_BIT];
    assign link_en     = ctrl_r[`FEQ_CTRL_LINK_BIT];
    assign single_mode = ctrl_r[`FEQ_CTRL_SINGLE_BIT];
    assign filt_on     = (mode == feq_pkg::FEQ_MODE_ENABLE);
    assign coef_a      = coef_a_r[SW-1:0];
    assign coef_b_eff  = (share || merge) ? coef_a : coef_b_r[SW-1:0];
    assign cfg_wr      = i_wr && (i_addr == `FEQ_OFS_CONFIG || i_addr == `FEQ_OFS_COEFF_A_TAP0 ||
                                  i_addr == `FEQ_OFS_COEFF_B_TAP0);

    // Gain trims: the first cycle after reset release copies the fuse values.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            fuse_done_r <= 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                gain_dual_r[i]   <= `FEQ_RST_GAIN;
                gain_single_r[i] <= `FEQ_RST_GAIN;
            end
        end
        else if (!fuse_done_r)
        begin
            fuse_done_r <= 1'b1;
            for (int i = 0; i < 4; i++)
            begin
                gain_dual_r[i]   <= {3'h0, i_fuse_gain_dual[i*GW +: GW]};
                gain_single_r[i] <= {3'h0, i_fuse_gain_single[i*GW +: GW]};
            end
        end
        else if (i_wr)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (i_addr == `FEQ_OFS_GAIN_A0_DUAL + 12'(i))
                begin
                    gain_dual_r[i] <= i_wdata[7:0];
                end
                if (i_addr == `FEQ_OFS_GAIN_A0_SINGLE + 12'(i))
                begin
                    gain_single_r[i] <= i_wdata[7:0];
                end
            end
        end
    end

    // Filter configuration, coefficients and control.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cfg_r    <= `FEQ_RST_CONFIG;
            coef_a_r <= `FEQ_RST_COEFF;
            coef_b_r <= `FEQ_RST_COEFF;
            ctrl_r   <= `FEQ_RST_CTRL;
        end
        else if (i_wr)
        begin
            unique case (i_addr)
                `FEQ_OFS_CONFIG:       cfg_r    <= i_wdata[7:0];
                `FEQ_OFS_COEFF_A_TAP0: coef_a_r <= i_wdata;
                `FEQ_OFS_COEFF_B_TAP0: coef_b_r <= i_wdata;
                `FEQ_OFS_CTRL:         ctrl_r   <= i_wdata[1:0];
                default:               ;
            endcase
        end
    end

    // A filter change with the link running is flagged; a new event wins over the clear.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cfg_hot_r <= 1'b0;
        end
        else if (cfg_wr && link_en)
        begin
            cfg_hot_r <= 1'b1;
        end
        else if (i_wr && i_addr == `FEQ_OFS_STATUS && i_wdata[`FEQ_STAT_CFGHOT_BIT])
        begin
            cfg_hot_r <= 1'b0;
        end
    end

    // Sample FIFO between the converter and the filter.
    logic              fifo_valid;
    logic [2*SW-1:0]   fifo_data;
    logic              fifo_pop;
    logic [4:0]        fifo_level_r;
    logic              out_adv;
    logic [SW-1:0]     cur_a;
    logic [SW-1:0]     cur_b;

    assign out_adv  = !o_eq_valid || i_eq_ready;
    // The filter drains only while the link runs, so a stopped link backs up into the FIFO.
    assign fifo_pop = fifo_valid && link_en && out_adv;
    assign cur_a    = fifo_data[SW-1:0];
    assign cur_b    = fifo_data[2*SW-1:SW];

    feq_fifo #(
        .WIDTH (2 * SW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (i_smp_valid),
        .i_in_data   ({i_smp_b, i_smp_a}),
        .o_in_ready  (o_smp_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (fifo_pop)
    );

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            fifo_level_r <= '0;
        end
        else if ((i_smp_valid && o_smp_ready) && !fifo_pop)
        begin
            fifo_level_r <= fifo_level_r + 5'h1;
        end
        else if (!(i_smp_valid && o_smp_ready) && fifo_pop)
        begin
            fifo_level_r <= fifo_level_r - 5'h1;
        end
    end

    // Filter stage: tap zero weighs the previous sample of its own stream.
    logic [SW-1:0] prev_a_r;
    logic [SW-1:0] prev_b_r;
    logic [SW-1:0] side_a;
    logic [SW-1:0] side_b;

    assign side_a = merge ? prev_b_r : prev_a_r;
    assign side_b = merge ? cur_a : prev_b_r;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            prev_a_r   <= '0;
            prev_b_r   <= '0;
            o_eq_valid <= 1'b0;
            o_eq_a     <= '0;
            o_eq_b     <= '0;
        end
        else if (fifo_pop)
        begin
            prev_a_r   <= cur_a;
            prev_b_r   <= cur_b;
            o_eq_valid <= 1'b1;
            o_eq_a     <= filt_on ? feq_tap(cur_a, side_a, coef_a, scw) : cur_a;
            o_eq_b     <= filt_on ? feq_tap(cur_b, side_b, coef_b_eff, scw) : cur_b;
        end
        else if (i_eq_ready)
        begin
            o_eq_valid <= 1'b0;
        end
    end

    // Active trim set follows the channel mode.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_gain_trim_a0 <= '0;
            o_gain_trim_a1 <= '0;
            o_gain_trim_b0 <= '0;
            o_gain_trim_b1 <= '0;
        end
        else
        begin
            o_gain_trim_a0 <= single_mode ? gain_single_r[0][GW-1:0] : gain_dual_r[0][GW-1:0];
            o_gain_trim_a1 <= single_mode ? gain_single_r[1][GW-1:0] : gain_dual_r[1][GW-1:0];
            o_gain_trim_b0 <= single_mode ? gain_single_r[2][GW-1:0] : gain_dual_r[2][GW-1:0];
            o_gain_trim_b1 <= single_mode ? gain_single_r[3][GW-1:0] : gain_dual_r[3][GW-1:0];
        end
    end

    // Read data stands for exactly the cycle after the read strobe.
    logic [`FEQ_DATA_W-1:0] rd_mux;

    always_comb
    begin
        rd_mux = '0;
        unique case (i_addr)
            `FEQ_OFS_GAIN_A0_DUAL:   rd_mux = {8'h00, gain_dual_r[0]};
            `FEQ_OFS_GAIN_A1_DUAL:   rd_mux = {8'h00, gain_dual_r[1]};
            `FEQ_OFS_GAIN_B0_DUAL:   rd_mux = {8'h00, gain_dual_r[2]};
            `FEQ_OFS_GAIN_B1_DUAL:   rd_mux = {8'h00, gain_dual_r[3]};
            `FEQ_OFS_GAIN_A0_SINGLE: rd_mux = {8'h00, gain_single_r[0]};
            `FEQ_OFS_GAIN_A1_SINGLE: rd_mux = {8'h00, gain_single_r[1]};
            `FEQ_OFS_GAIN_B0_SINGLE: rd_mux = {8'h00, gain_single_r[2]};
            `FEQ_OFS_GAIN_B1_SINGLE: rd_mux = {8'h00, gain_single_r[3]};
            `FEQ_OFS_CONFIG:         rd_mux = {8'h00, cfg_r};
            `FEQ_OFS_COEFF_A_TAP0:   rd_mux = coef_a_r;
            `FEQ_OFS_COEFF_B_TAP0:   rd_mux = coef_b_r;
            `FEQ_OFS_CTRL:           rd_mux = {14'h0000, ctrl_r};
            `FEQ_OFS_STATUS:         rd_mux = {10'h000, cfg_hot_r, filt_on, fifo_level_r[3:0]};
            default:                 rd_mux = '0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_rdata <= '0;
        end
        else if (i_rd)
        begin
            o_rdata <= rd_mux;
        end
        else
        begin
            o_rdata <= '0;
        end
    end

endmodule // feq_equalizer

`default_nettype wire

//--- feq_equalizer_checker.sv
// Port-level assertions for the equalizer and gain trim block.
`timescale 1ns/1ps
`default_nettype none
`include "feq_defines.svh"
module feq_equalizer_checker #(
    parameter int FIFO_DEPTH = `FEQ_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic                   i_clk,
    input wire logic                   i_arst_n,
    // Register port.
    input wire logic [`FEQ_ADDR_W-1:0] i_addr,
    input wire logic [`FEQ_DATA_W-1:0] i_wdata,
    input wire logic                   i_wr,
    input wire logic                   i_rd,
    input wire logic [`FEQ_DATA_W-1:0] o_rdata,
    // Equalized samples.
    input wire logic                   o_eq_valid,
    input wire logic [`FEQ_SMP_W-1:0]  o_eq_a,
    input wire logic [`FEQ_SMP_W-1:0]  o_eq_b,
    input wire logic                   i_eq_ready,
    // Active trims.
    input wire logic [`FEQ_GAIN_W-1:0] o_gain_trim_a0,
    input wire logic [`FEQ_GAIN_W-1:0] o_gain_trim_b1
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // Shadow control bits, since the checker cannot see the registers themselves.
    logic       link_r;
    logic       single_r;
    logic [1:0] mode_r;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            link_r <= 1'b0;
            single_r <= 1'b0;
        end
        else if (i_wr && i_addr == `FEQ_OFS_CTRL)
        begin
            link_r <= i_wdata[0];
            single_r <= i_wdata[1];
        end
    end
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            mode_r <= 2'h0;
        else if (i_wr && i_addr == `FEQ_OFS_CONFIG)
            mode_r <= i_wdata[1:0];
    end
    property p_gain_upper;
        i_rd && i_addr >= 12'h350 && i_addr <= 12'h357 |=> o_rdata[15:8] == 8'h00;
    endproperty
    a_gain_upper: assert property (p_gain_upper) else $error("gain read upper byte not zero");
    property p_trim_dual;
        i_wr && i_addr == `FEQ_OFS_GAIN_B1_DUAL && !single_r |=> ##1 o_gain_trim_b1 == $past(i_wdata[4:0], 2);
    endproperty
    a_trim_dual: assert property (p_trim_dual) else $error("dual trim not applied");
    property p_trim_single;
        i_wr && i_addr == `FEQ_OFS_GAIN_A0_SINGLE && single_r |=> ##1 o_gain_trim_a0 == $past(i_wdata[4:0], 2);
    endproperty
    a_trim_single: assert property (p_trim_single) else $error("single trim not applied");
    property p_cfg_rb;
        i_wr && i_addr == `FEQ_OFS_CONFIG ##1 i_rd && i_addr == `FEQ_OFS_CONFIG
            |=> o_rdata == {8'h00, $past(i_wdata[7:0], 2)};
    endproperty
    a_cfg_rb: assert property (p_cfg_rb) else $error("config readback wrong");
    property p_coef_rb;
        i_wr && i_addr == `FEQ_OFS_COEFF_A_TAP0 ##1 i_rd && i_addr == `FEQ_OFS_COEFF_A_TAP0
            |=> o_rdata == $past(i_wdata, 2);
    endproperty
    a_coef_rb: assert property (p_coef_rb) else $error("coefficient readback wrong");
    property p_hold;
        o_eq_valid && !i_eq_ready |=> o_eq_valid && $stable(o_eq_a) && $stable(o_eq_b);
    endproperty
    a_hold: assert property (p_hold) else $error("output pair changed while stalled");
    property p_drain_link;
        $rose(o_eq_valid) |-> $past(link_r);
    endproperty
    a_drain_link: assert property (p_drain_link) else $error("output produced with link off");
    property p_mode_stat;
        i_rd && i_addr == `FEQ_OFS_STATUS |=> o_rdata[4] == (mode_r == 2'h2);
    endproperty
    a_mode_stat: assert property (p_mode_stat) else $error("mode decode wrong");
endmodule // feq_equalizer_checker
bind feq_equalizer feq_equalizer_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_eq_valid(o_eq_valid), .o_eq_a(o_eq_a), .o_eq_b(o_eq_b), .i_eq_ready(i_eq_ready),
    .o_gain_trim_a0(o_gain_trim_a0), .o_gain_trim_b1(o_gain_trim_b1));
`default_nettype wire

//--- tb_fir_equalizer_and_gain_trim.sv
// Self-checking bench for the equalizer and gain trim block.
`timescale 1ns/1ps
`default_nettype none
`include "feq_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_fir_equalizer_and_gain_trim;
    localparam int DEPTH = 8;
    localparam logic [19:0] FUSE_D = 20'hA_5C3B;
    localparam logic [19:0] FUSE_S = 20'h3_96E4;
    logic        i_clk, i_arst_n, i_wr, i_rd, i_smp_valid, i_eq_ready, o_smp_ready, o_eq_valid;
    logic [11:0] i_addr, i_smp_a, i_smp_b, o_eq_a, o_eq_b, pa, pb;
    logic [15:0] i_wdata, o_rdata, q;
    logic [4:0]  o_gain_trim_a0, o_gain_trim_a1, o_gain_trim_b0, o_gain_trim_b1;
    int          n_fail = 0;
    int          check_count = 0;
    feq_equalizer #(.FIFO_DEPTH(DEPTH)) uut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_fuse_gain_dual(FUSE_D), .i_fuse_gain_single(FUSE_S),
        .i_smp_valid(i_smp_valid), .i_smp_a(i_smp_a), .i_smp_b(i_smp_b), .o_smp_ready(o_smp_ready),
        .o_eq_valid(o_eq_valid), .o_eq_a(o_eq_a), .o_eq_b(o_eq_b), .i_eq_ready(i_eq_ready),
        .o_gain_trim_a0(o_gain_trim_a0), .o_gain_trim_a1(o_gain_trim_a1),
        .o_gain_trim_b0(o_gain_trim_b0), .o_gain_trim_b1(o_gain_trim_b1));
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // Write then read the same place back to back, the tightest legal spacing.
    task automatic wr_rd(input logic [11:0] a, input logic [15:0] d, output logic [15:0] r);
        wr(a, d);
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 r = o_rdata;
    endtask
    function automatic logic [11:0] sat12(input int v);
        if (v > 2047)
            return 12'h7FF;
        if (v < -2048)
            return 12'h800;
        return v[11:0];
    endfunction
    function automatic logic [11:0] eqf(input logic [11:0] x, s, c, input int w);
        int p;
        p = (int'($signed(c)) * int'($signed(s))) <<< w;
        p = p >>> 16;
        // The scaled side term is not clipped on its own; only the final sum saturates.
        return sat12(int'($signed(x)) + p);
    endfunction
    task automatic send(input logic [11:0] a, b, ea, eb);
        int n;
        n = 0;
        @(posedge i_clk);
        i_smp_valid <= 1'b1;
        i_smp_a <= a;
        i_smp_b <= b;
        @(posedge i_clk);
        i_smp_valid <= 1'b0;
        #1;
        while (o_eq_valid !== 1'b1 && n < 20)
        begin
            @(posedge i_clk);
            #1 n++;
        end
        `CHK(o_eq_valid, 1'b1)
        `CHK(o_eq_a, ea)
        `CHK(o_eq_b, eb)
        @(posedge i_clk);
        i_eq_ready <= 1'b1;
        @(posedge i_clk);
        i_eq_ready <= 1'b0;
    endtask
    task automatic t_regs;
        for (int k = 0; k < 4; k++)
        begin
            rd(12'h350 + 12'(k), q);
            `CHK(q, {11'h0, FUSE_D[5*k +: 5]})
            rd(12'h354 + 12'(k), q);
            `CHK(q, {11'h0, FUSE_S[5*k +: 5]})
        end
        `CHK(o_gain_trim_a0, FUSE_D[4:0])
        `CHK(o_gain_trim_a1, FUSE_D[9:5])
        `CHK(o_gain_trim_b0, FUSE_D[14:10])
        wr_rd(`FEQ_OFS_GAIN_B1_DUAL, 16'h00FF, q);
        `CHK(q, 16'h00FF)
        `CHK(o_gain_trim_b1, 5'h1F)
        wr(`FEQ_OFS_CONFIG, 16'h0020);
        wr(`FEQ_OFS_CTRL, 16'h0002);
        wr_rd(`FEQ_OFS_GAIN_A0_SINGLE, 16'h00E6, q);
        `CHK(q, 16'h00E6)
        `CHK(o_gain_trim_a0, 5'h06)
        `CHK(o_gain_trim_b1, FUSE_S[19:15])
        wr(`FEQ_OFS_CTRL, 16'h0000);
        wr_rd(`FEQ_OFS_CONFIG, 16'h00E0, q);
        `CHK(q, 16'h00E0)
        rd(12'h401, q);
        `CHK(q, 16'h0000)
    endtask
    task automatic t_filter;
        logic [7:0]  cfg [8] = '{8'h12, 8'h52, 8'h32, 8'h1A, 8'h02, 8'h13, 8'h11, 8'h80};
        logic [11:0] av [3] = '{12'h7F0, 12'h805, 12'h123};
        logic [11:0] bv [3] = '{12'h800, 12'h0FF, 12'hF00};
        logic [11:0] ca, cb, sa, sb, cx;
        ca = 12'h4D2;
        cb = 12'hB2E;
        // Reserved coefficient bits are set on purpose; they must not reach the taps.
        wr_rd(`FEQ_OFS_COEFF_A_TAP0, 16'h54D2, q);
        `CHK(q, 16'h54D2)
        wr(`FEQ_OFS_COEFF_B_TAP0, 16'hAB2E);
        for (int i = 0; i < 8; i++)
        begin
            wr(`FEQ_OFS_CTRL, 16'h0000);
            wr(`FEQ_OFS_CONFIG, {8'h00, cfg[i]});
            rd(`FEQ_OFS_STATUS, q);
            `CHK(q[4], cfg[i][1:0] == 2'h2)
            wr(`FEQ_OFS_CTRL, 16'h0001);
            for (int j = 0; j < 3; j++)
            begin
                sa = cfg[i][5] ? pb : pa;
                sb = cfg[i][5] ? av[j] : pb;
                cx = (cfg[i][5] || cfg[i][6]) ? ca : cb;
                if (cfg[i][1:0] == 2'h2)
                    send(av[j], bv[j], eqf(av[j], sa, ca, cfg[i][4:2]), eqf(bv[j], sb, cx, cfg[i][4:2]));
                else
                    send(av[j], bv[j], av[j], bv[j]);
                pa = av[j];
                pb = bv[j];
            end
        end
    endtask
    task automatic t_fifo;
        int n;
        int m;
        logic r;
        n = 0;
        m = 0;
        wr(`FEQ_OFS_CTRL, 16'h0000);
        i_smp_valid <= 1'b1;
        repeat (16)
        begin
            #1 r = o_smp_ready;
            @(posedge i_clk);
            if (r)
                n++;
        end
        i_smp_valid <= 1'b0;
        `CHK(n, DEPTH)
        rd(`FEQ_OFS_STATUS, q);
        `CHK(q[3:0], 4'(DEPTH))
        wr(`FEQ_OFS_CTRL, 16'h0001);
        i_eq_ready <= 1'b1;
        repeat (30)
        begin
            @(posedge i_clk);
            #1 if (o_eq_valid === 1'b1)
                m++;
        end
        `CHK(m, DEPTH)
        rd(`FEQ_OFS_STATUS, q);
        `CHK(q[3:0], 4'h0)
        // A deliberate change with the link running must raise the sticky flag until cleared.
        wr(`FEQ_OFS_COEFF_B_TAP0, 16'h0000);
        rd(`FEQ_OFS_STATUS, q);
        `CHK(q[5], 1'b1)
        wr(`FEQ_OFS_STATUS, 16'h0020);
        rd(`FEQ_OFS_STATUS, q);
        `CHK(q[5], 1'b0)
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // The whole sequence needs well under 2000 cycles; this leaves ample margin.
    initial
    begin
        #100000;
        n_fail++;
        print_verdict();
    end
    initial
    begin
        {i_arst_n, i_wr, i_rd, i_smp_valid, i_eq_ready} = '0;
        {i_addr, i_wdata, i_smp_a, i_smp_b, pa, pb} = '0;
        repeat (16) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        t_regs();
        t_filter();
        t_fifo();
        print_verdict();
    end
endmodule // tb_fir_equalizer_and_gain_trim
`default_nettype wire
